// [logic/esa_pkg.sv]
// package: constants and carrier types for the static memory access controller
package esa_pkg;
   localparam int CLK_PERIOD_PS = 25000;
   // times in picoseconds, as printed in ns
   localparam int T_CYCLE_PS    = 10000;
   localparam int T_ACCESS_PS   = 11000;
   localparam int T_SETUP_PS    = 1000;
   localparam int T_OVERLAP_PS  = 7000;
   localparam int T_HOLD_PS     = 1000;
   // least times, rounded up to whole cycles, at least one
   localparam int C_CYCLE   = (T_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int C_ACCESS  = (T_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int C_SETUP   = (T_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int C_OVERLAP = (T_OVERLAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int C_HOLD    = (T_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ADDR_W    = 21;
   localparam int DATA_W    = 4;
   localparam logic [3:0] CNT_RST = 4'h0;

   typedef struct packed {
      logic              write;
      logic              narrow;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } esa_req_t;

   typedef struct packed {
      logic              sel_n;
      logic              wen_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } esa_pins_t;
endpackage

// [logic/esa_sync.sv]
// two-flop synchroniser for the read outputs of the memory
`timescale 1ns/10ps
`default_nettype none
module esa_sync
   import esa_pkg::*;
#(
   parameter int WIDTH = 4
)
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// [logic/esa_ctrl.sv]
// controller that drives the asynchronous static memory through its pins
`timescale 1ns/10ps
`default_nettype none
module esa_ctrl
   import esa_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   input  wire esa_req_t          req,
   input  wire logic              req_valid,
   output logic                   req_ready,
   output logic                   rd_valid,
   output logic      [DATA_W-1:0] rd_data,
   output esa_pins_t              pins,
   output logic                   narrow_sel,
   input  wire logic [DATA_W-1:0] read_outputs
);
   initial
   begin
      if (C_OVERLAP < 1 || C_ACCESS < 1)
         $error("timing counts must be at least one cycle");
   end

   // ****************************************
   // state machine
   // ****************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_OVLP  = 5'h04,
      ST_HOLD  = 5'h08,
      ST_READ  = 5'h10
   } esa_state_t;

   esa_state_t        state_q, state_d;
   logic [3:0]        cnt_q, cnt_d;
   esa_pins_t         pins_q, pins_d;
   esa_req_t          cur_q, cur_d;
   logic              ready_q, ready_d;
   logic              rdv_q, rdv_d;
   logic [DATA_W-1:0] rdat_q, rdat_d;
   logic              narrow_q, narrow_d;
   logic [DATA_W-1:0] q_sync;

   esa_sync #(.WIDTH(DATA_W)) u_sync (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (read_outputs),
      .sync_out (q_sync)
   );

   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      pins_d   = pins_q;
      cur_d    = cur_q;
      ready_d  = 1'b0;
      rdv_d    = 1'b0;
      rdat_d   = rdat_q;
      narrow_d = narrow_q;
      unique case (state_q)
         ST_IDLE:
         begin
            ready_d = 1'b1;
            if (req_valid && ready_q)
            begin
               cur_d        = req;
               narrow_d     = req.narrow;
               pins_d.addr  = req.addr;              // address before select
               pins_d.wdata = req.wdata;
               pins_d.wen_n = 1'b1;
               pins_d.sel_n = 1'b1;
               ready_d      = 1'b0;
               cnt_d        = 4'(C_SETUP - 1);
               state_d      = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (cnt_q == CNT_RST)
            begin
               // select low with or before write enable
               pins_d.sel_n = 1'b0;
               pins_d.wen_n = !cur_q.write;
               cnt_d = cur_q.write ? 4'(C_OVERLAP - 1)
                                   : 4'(C_ACCESS + 2);
               state_d = cur_q.write ? ST_OVLP : ST_READ;
            end
            else
               cnt_d = cnt_q - 4'h1;
         end
         ST_OVLP:
         begin
            // overlap long enough, data and address stable
            if (cnt_q == CNT_RST)
            begin
               pins_d.wen_n = 1'b1;
               pins_d.sel_n = 1'b1;
               cnt_d        = 4'(C_HOLD - 1);
               state_d      = ST_HOLD;
            end
            else
               cnt_d = cnt_q - 4'h1;
         end
         ST_READ:
         begin
            // waits out access time plus synchroniser
            if (cnt_q == CNT_RST)
            begin
               rdat_d       = q_sync;
               rdv_d        = 1'b1;
               pins_d.sel_n = 1'b1;
               cnt_d        = 4'(C_HOLD - 1);
               state_d      = ST_HOLD;
            end
            else
               cnt_d = cnt_q - 4'h1;
         end
         ST_HOLD:
         begin
            // address and data held past the end
            if (cnt_q == CNT_RST)
            begin
               state_d = ST_IDLE;
               ready_d = 1'b1;
            end
            else
               cnt_d = cnt_q - 4'h1;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_q  <= ST_IDLE;
         cnt_q    <= CNT_RST;
         pins_q   <= '{sel_n: 1'b1, wen_n: 1'b1, addr: '0, wdata: '0};
         cur_q    <= '0;
         ready_q  <= 1'b0;
         rdv_q    <= 1'b0;
         rdat_q   <= '0;
         narrow_q <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         pins_q   <= pins_d;
         cur_q    <= cur_d;
         ready_q  <= ready_d;
         rdv_q    <= rdv_d;
         rdat_q   <= rdat_d;
         narrow_q <= narrow_d;
      end
   end

   assign req_ready  = ready_q;
   assign rd_valid   = rdv_q;
   assign rd_data    = rdat_q;
   assign pins       = pins_q;
   assign narrow_sel = narrow_q;

   // ****************************************
   // checks
   // ****************************************
   sequence ovl_start_s;
      !pins_q.sel_n && !pins_q.wen_n && $fell(pins_q.wen_n);
   endsequence

   write_needs_sel_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !pins_q.wen_n |-> !pins_q.sel_n)
      else $error("write enable low without select");
   read_wen_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
      state_q == ST_READ |-> pins_q.wen_n)
      else $error("write enable low in read");
   overlap_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ovl_start_s |-> !pins_q.wen_n [*1])
      else $error("write overlap too short");
   addr_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !pins_q.sel_n |-> $stable(pins_q.addr))
      else $error("address moved while selected");
   data_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !pins_q.wen_n |-> $stable(pins_q.wdata))
      else $error("write data moved during overlap");
   sel_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(pins_q.wen_n) |-> $past(!pins_q.sel_n) || !pins_q.sel_n)
      else $error("write enable fell before select");
   hold_after_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(pins_q.sel_n) |-> $stable(pins_q.addr) && $stable(pins_q.wdata))
      else $error("address changed at end of cycle");
   read_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $fell(pins_q.sel_n) && pins_q.wen_n |-> !pins_q.sel_n [*3])
      else $error("read select too short");
   ready_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ready_q |-> pins_q.sel_n)
      else $error("ready while cycle active");
endmodule
`default_nettype wire

// [dv/esa_mem_model.sv]
// behavioural model of the asynchronous static memory
`timescale 1ns/10ps
`default_nettype none
module esa_mem_model
   import esa_pkg::*;
(
   input  wire esa_pins_t         pins,
   input  wire logic              narrow_sel,
   output logic      [DATA_W-1:0] read_outputs
);
   logic [DATA_W-1:0] mem [logic [ADDR_W:0]];
   logic [DATA_W-1:0] word;
   initial read_outputs = 4'h0;
   // store as the select and write enable overlap closes
   always @(posedge (pins.sel_n | pins.wen_n))
      mem[{narrow_sel, pins.addr}] = pins.wdata;
   always @(pins.sel_n, pins.wen_n, pins.addr, narrow_sel)
   begin
      if (pins.sel_n || !pins.wen_n)
         read_outputs <= #7 4'h0;
      else
      begin
         word = mem.exists({narrow_sel, pins.addr}) ?
                mem[{narrow_sel, pins.addr}] : 4'h0;
         if (narrow_sel)
            word = {~word[1:0], word[1:0]};
         // junk between hold and access, never a stale match
         read_outputs <= #4 ~read_outputs;
         read_outputs <= #10 word;
      end
   end
endmodule
`default_nettype wire

// [dv/ecl_async_sram_access_tb_top.sv]
// self-checking bench for the static memory access controller
`timescale 1ns/10ps
`default_nettype none
module ecl_async_sram_access_tb_top
   import esa_pkg::*;
;
   logic              mclk;
   logic              sys_rst;
   logic              req_valid;
   logic              req_ready;
   logic              rd_valid;
   logic              narrow_sel;
   esa_req_t          req;
   esa_pins_t         pins;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] read_outputs;
   logic [DATA_W-1:0] shadow [logic [ADDR_W:0]];
   logic [31:0]       r;
   int                fails;
   int                samples_checked;
   int                seed;

   esa_ctrl esa_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .pins(pins), .narrow_sel(narrow_sel),
      .read_outputs(read_outputs));
   esa_mem_model esa_mem_model_i (.pins(pins), .narrow_sel(narrow_sel),
      .read_outputs(read_outputs));

   always #12.5 mclk = ~mclk;

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // narrow words carry two bits only
   function automatic logic [3:0] fold(input logic nr, input logic [3:0] d);
      return nr ? {2'h0, d[1:0]} : d;
   endfunction

   // one request, entered at a falling edge, left at a falling edge
   task automatic xfer(input logic wr, input logic nr,
                       input logic [ADDR_W-1:0] a, input logic [3:0] d);
      int n;
      int ovl;
      logic [3:0] got;
      ovl = 0;
      got = 'x;
      n = 0;
      req <= '{wr, nr, a, d};
      req_valid <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         fails++;
         give_verdict();
      end
      @(negedge mclk);
      req_valid <= 1'b0;
      for (n = 0; n < 12; n++)
      begin
         @(posedge mclk);
         if (n == 1)
            check(narrow_sel, nr);
         if (!wr)
            check(pins.wen_n, 1'b1);
         if (!wr && rd_valid === 1'b1)
            got = rd_data;
         if (wr && pins.wen_n === 1'b0)
            check(pins.sel_n, 1'b0);
         if (wr && !pins.sel_n && !pins.wen_n)
         begin
            ovl++;
            check(pins.addr, a);
            check(fold(nr, pins.wdata), fold(nr, d));
         end
      end
      if (wr)
      begin
         check(ovl, 1);
         shadow[{nr, a}] = fold(nr, d);
      end
      else
         check(fold(nr, got), shadow.exists({nr, a}) ?
               shadow[{nr, a}] : 4'h0);
      @(negedge mclk);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      fails = 0;
      samples_checked = 0;
      seed = 18407;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      xfer(1'b1, 1'b0, 21'h1FFFFF, 4'hF);
      xfer(1'b0, 1'b0, 21'h1FFFFF, 4'h0);
      xfer(1'b1, 1'b1, 21'h000000, 4'h2);
      xfer(1'b0, 1'b1, 21'h000000, 4'h0);
      xfer(1'b0, 1'b0, 21'h000000, 4'h0);
      repeat (200)
      begin
         r = $random(seed);
         xfer(r[0], r[1], {18'h0, r[4:2]}, r[8:5]);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
